/* File: include/ohm_pkg.sv */
/*
 Package for the one-hot Moore table state machine: sizes, state
 indices, the transition table and the condition operators.
 Assumes a single clock domain and integer inputs below 2**25.
*/
package ohm_pkg;

	localparam int NUM_INPUTS  = 5;
	localparam int NUM_STATES  = 5;
	localparam int NUM_ENTRIES = 5;
	localparam int DATA_W      = 32;
	localparam int SAFE_MAG_W  = 25;
	localparam int STATE_W     = 3;
	localparam int INPUT_W     = 3;

	// State indices
	localparam logic [STATE_W-1:0] ST_S1 = 3'h0;
	localparam logic [STATE_W-1:0] ST_S2 = 3'h1;
	localparam logic [STATE_W-1:0] ST_S3 = 3'h2;
	localparam logic [STATE_W-1:0] ST_S4 = 3'h3;
	localparam logic [STATE_W-1:0] ST_S5 = 3'h4;
	localparam logic [STATE_W-1:0] RESET_STATE = ST_S1;

	// Comparison operators
	typedef enum logic [2:0] {
		OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE, OP_TRUE
	} ohm_op_e;

	// One comparison term: input against constant
	typedef struct packed {
		logic              used;
		logic              negate;
		logic [INPUT_W-1:0] sel;
		ohm_op_e           op;
		logic [DATA_W-1:0] value;
	} ohm_term_s;

	// One table entry: source, up to three terms, destination
	localparam int NUM_TERMS = 3;
	typedef struct packed {
		logic [STATE_W-1:0] src;
		logic               any_of;
		ohm_term_s [NUM_TERMS-1:0] term;
		logic [STATE_W-1:0] dst;
	} ohm_entry_s;

	typedef ohm_entry_s [NUM_ENTRIES-1:0] ohm_table_t;

	localparam ohm_term_s T_NONE  = '{1'b0, 1'b0, 3'h0, OP_TRUE, 32'h0000_0000};
	localparam ohm_term_s T_IN2_1 = '{1'b1, 1'b0, 3'h1, OP_EQ, 32'h0000_0001};
	localparam ohm_term_s T_IN3_1 = '{1'b1, 1'b0, 3'h2, OP_EQ, 32'h0000_0001};
	localparam ohm_term_s T_IN4_1 = '{1'b1, 1'b0, 3'h3, OP_EQ, 32'h0000_0001};
	localparam ohm_term_s T_IN5_0 = '{1'b1, 1'b0, 3'h4, OP_EQ, 32'h0000_0000};
	localparam ohm_term_s T_IN5_1 = '{1'b1, 1'b0, 3'h4, OP_EQ, 32'h0000_0001};
	localparam ohm_term_s T_ONE   = '{1'b1, 1'b0, 3'h0, OP_TRUE, 32'h0000_0000};

	// Default table, ordered by priority (index 0 first)
	localparam ohm_table_t DEFAULT_TABLE = '{
		'{ST_S5, 1'b0, '{T_NONE, T_NONE, T_ONE}, ST_S1},
		'{ST_S2, 1'b0, '{T_NONE, T_IN3_1, T_IN2_1}, ST_S3},
		'{ST_S4, 1'b0, '{T_NONE, T_NONE, T_IN5_1}, ST_S5},
		'{ST_S3, 1'b0, '{T_IN4_1, T_IN3_1, T_IN2_1}, ST_S4},
		'{ST_S1, 1'b0, '{T_NONE, T_NONE, T_IN2_1}, ST_S2}
	};
	localparam ohm_table_t DEFAULT_TABLE_B = DEFAULT_TABLE;

	// Second entry for s3 kept as a separate constant, appended below
	localparam ohm_entry_s ENTRY_S3B = '{ST_S3, 1'b0, '{T_NONE, T_IN5_0, T_IN4_1}, ST_S4};

	// Static legality check of a table
	function automatic logic table_legal(input ohm_table_t tbl);
		logic [NUM_STATES-1:0] has_out;
		logic                  ok;
		has_out = '0;
		ok      = (NUM_STATES >= 2) && (NUM_ENTRIES >= 2);
		for (int e = 0; e < NUM_ENTRIES; e++) begin
			if (int'(tbl[e].src) >= NUM_STATES || int'(tbl[e].dst) >= NUM_STATES)
				ok = 1'b0;
			else
				has_out[tbl[e].src] = 1'b1;
			for (int t = 0; t < NUM_TERMS; t++) begin
				if (tbl[e].term[t].used && int'(tbl[e].term[t].sel) >= NUM_INPUTS)
					ok = 1'b0;
			end
		end
		if (!(&has_out))
			ok = 1'b0;
		if (int'(RESET_STATE) >= NUM_STATES)
			ok = 1'b0;
		return ok;
	endfunction

endpackage

/* File: rtl/ohm_fsm.sv */
/*
 One-hot Moore state machine driven by an ordered transition table.
 Each state has one output, high only while that state is current.
 Entries are tried in list order; the first true entry of the current
 state sets the next state, and with none true the state is held.
 An illegal table parks the machine in its reset state.
 Assumes inputs come from logic on the same clock, so none is synchronised,
 and that they stay below 2**25; larger values only raise a warning.
*/
`timescale 1ns/10ps
`default_nettype none

module ohm_fsm
	import ohm_pkg::*;
(
	// Clock and reset
	input  wire logic                          i_clock,
	input  wire logic                          i_resetn,
	// Synchronous machine reset
	input  wire logic                          i_sm_reset,
	// Integer inputs, input k in bits [k*32 +: 32]
	input  wire logic [NUM_INPUTS*DATA_W-1:0]  i_inputs,
	// One output per state
	output logic      [NUM_STATES-1:0]         o_state,
	// Input above the safe magnitude seen while running
	output logic                               o_range_warn
);

	localparam int NUM_ALL = NUM_ENTRIES + 1;
	localparam logic [NUM_STATES-1:0] STATE_RST = NUM_STATES'(1) << RESET_STATE;

	// Table widened by one slot for the appended s3 entry
	typedef ohm_entry_s [NUM_ALL-1:0] ohm_full_t;

	// appended entry checked
	// The package check covers the five default entries only, so the extra
	// s3 entry is held to the same rules here
	function automatic logic entry_legal(input ohm_entry_s ent);
		logic ok;
		ok = (int'(ent.src) < NUM_STATES) && (int'(ent.dst) < NUM_STATES);
		for (int t = 0; t < NUM_TERMS; t++) begin
			if (ent.term[t].used && int'(ent.term[t].sel) >= NUM_INPUTS)
				ok = 1'b0;
		end
		return ok;
	endfunction

	localparam logic TABLE_OK = table_legal(DEFAULT_TABLE) && entry_legal(ENTRY_S3B);

	// Priority order: the five default entries, then the second s3 entry
	ohm_full_t table_q;
	assign table_q = {ENTRY_S3B, DEFAULT_TABLE};

	logic [NUM_ALL-1:0][NUM_TERMS-1:0] term_true;
	logic [NUM_ALL-1:0]                cond_true;

	// negation per term
	// Every entry gets a full set of comparators, used or not; unused slots are
	// masked in the join below, so the table stays a pure constant
	genvar ge, gt;
	generate
		for (ge = 0; ge < NUM_ALL; ge++) begin : g_entry
			for (gt = 0; gt < NUM_TERMS; gt++) begin : g_term
				ohm_term u_term (
					.i_term   (table_q[ge].term[gt]),
					.i_inputs (i_inputs),
					.o_true   (term_true[ge][gt])
				);
			end
		end
	endgenerate

	// constant one
	// An entry whose slots are all unused is true under AND and false under OR
	always_comb begin
		logic all_t;
		logic any_t;
		all_t     = 1'b1;
		any_t     = 1'b0;
		cond_true = '0;
		for (int e = 0; e < NUM_ALL; e++) begin
			all_t = 1'b1;
			any_t = 1'b0;
			for (int t = 0; t < NUM_TERMS; t++) begin
				if (table_q[e].term[t].used) begin
					all_t = all_t & term_true[e][t];
					any_t = any_t | term_true[e][t];
				end
			end
			cond_true[e] = table_q[e].any_of ? any_t : all_t;
		end
	end

	// State register and its next value
	logic [STATE_W-1:0]    cur_r;
	logic [STATE_W-1:0]    cur_nxt;
	logic [NUM_STATES-1:0] state_r;
	logic [NUM_STATES-1:0] state_nxt;
	logic                  state_load;

	// Entry selection
	logic [NUM_ALL-1:0]    src_match;
	logic [NUM_ALL-1:0]    cand;
	logic [NUM_ALL-1:0]    pick;
	logic [STATE_W-1:0]    pick_dst;
	logic                  hit;

	// Range warning
	logic                  warn_r;
	logic                  warn_nxt;

	always_comb begin
		src_match = '0;
		for (int e = 0; e < NUM_ALL; e++) begin
			src_match[e] = (table_q[e].src == cur_r);
		end
		cand = src_match & cond_true;
	end

	// earliest wins
	// Only the lowest-numbered candidate passes the running mask, so two true
	// entries of one state never both reach the destination mux
	always_comb begin
		logic seen;
		seen = 1'b0;
		pick = '0;
		for (int e = 0; e < NUM_ALL; e++) begin
			pick[e] = cand[e] & ~seen;
			seen    = seen | cand[e];
		end
		// High when any entry of the current state is true
		hit = seen;
	end

	// Pick is one-hot or zero, so or-ing the picked destinations is a plain mux
	always_comb begin
		pick_dst = '0;
		for (int e = 0; e < NUM_ALL; e++) begin
			if (pick[e])
				pick_dst = pick_dst | table_q[e].dst;
		end
	end

	// Next state and its one-hot image
	always_comb begin
		cur_nxt = cur_r;
		if (hit)
			cur_nxt = pick_dst;
		// refuse bad table
		// An illegal table parks the machine in its reset state rather than
		// run transitions that may name states that do not exist
		if (!TABLE_OK)
			cur_nxt = RESET_STATE;
		// reset state
		// Tested last so the dedicated reset input beats any transition
		if (i_sm_reset)
			cur_nxt = RESET_STATE;
		state_nxt = '0;
		for (int s = 0; s < NUM_STATES; s++) begin
			state_nxt[s] = (cur_nxt == STATE_W'(s));
		end
		// Registers load only on a change, so a held state costs no toggling
		state_load = (cur_nxt != cur_r);
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			cur_r   <= RESET_STATE;
			state_r <= STATE_RST;
		end else if (state_load) begin
			cur_r   <= cur_nxt;
			state_r <= state_nxt;
		end
	end

	// range watch
	// Diagnostic only: the compares stay exact in 32 bits, this just flags
	// driving logic that has left the safe range
	always_comb begin
		warn_nxt = 1'b0;
		for (int k = 0; k < NUM_INPUTS; k++) begin
			if (|i_inputs[k*DATA_W+SAFE_MAG_W +: DATA_W-SAFE_MAG_W])
				warn_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			warn_r <= 1'b0;
		else
			warn_r <= warn_nxt;
	end

	assign o_state      = state_r;
	assign o_range_warn = warn_r;

endmodule

`default_nettype wire

/* File: rtl/ohm_term.sv */
/*
 One comparison term: a selected input against a constant, with
 optional negation applied after the compare.
 Assumes inputs and constants are unsigned and below 2**25.
*/
`timescale 1ns/10ps
`default_nettype none

module ohm_term
	import ohm_pkg::*;
(
	// Term description and inputs
	input  wire ohm_term_s                     i_term,
	input  wire logic [NUM_INPUTS*DATA_W-1:0]  i_inputs,
	// Result
	output logic                               o_true
);

	logic [DATA_W-1:0] operand;
	logic              cmp;

	always_comb begin
		operand = i_inputs[i_term.sel*DATA_W +: DATA_W];
		case (i_term.op)
			OP_EQ:   cmp = (operand == i_term.value);
			OP_NE:   cmp = (operand != i_term.value);
			OP_GT:   cmp = (operand >  i_term.value);
			OP_GE:   cmp = (operand >= i_term.value);
			OP_LT:   cmp = (operand <  i_term.value);
			OP_LE:   cmp = (operand <= i_term.value);
			OP_TRUE: cmp = 1'b1;
			default: cmp = 1'b0;
		endcase
		// Negation binds before the term joins the and/or combination
		o_true = i_term.negate ? ~cmp : cmp;
	end

endmodule

`default_nettype wire

/* File: test/ohm_datapath.sv */
/*
 Model of the user datapath that feeds the machine's inputs.
 Assumes the bench hands it one random word per cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module ohm_datapath
	import ohm_pkg::*;
(
	input  wire logic [31:0]                 i_word,
	output logic      [NUM_INPUTS*DATA_W-1:0] o_inputs
);
	// inputs kept small, only in1 may cross the bound to raise the warning
	always_comb begin
		o_inputs = '0;
		o_inputs[0 +: DATA_W] = {6'h00, i_word[31:6]};
		for (int k = 1; k < NUM_INPUTS; k++) begin
			o_inputs[k*DATA_W +: 2] = i_word[2*k-2 +: 2];
		end
	end
endmodule

`default_nettype wire

/* File: test/ohm_fsm_properties.sv */
/*
 Checker for the one-hot table machine, bound to ohm_fsm.
 Assumes one clock domain and the default table of the package.
*/
`timescale 1ns/10ps
`default_nettype none

module ohm_fsm_properties
	import ohm_pkg::*;
(
	input wire logic                         i_clock,
	input wire logic                         i_resetn,
	input wire logic                         i_sm_reset,
	input wire logic [NUM_INPUTS*DATA_W-1:0] i_inputs,
	input wire logic [NUM_STATES-1:0]        o_state,
	input wire logic                         o_range_warn
);
	localparam logic [DATA_W-1:0] ONE = 32'h0000_0001;
	logic              go;
	logic              big;
	logic [DATA_W-1:0] in2, in3, in4, in5;
	assign in2 = i_inputs[1*DATA_W +: DATA_W];
	assign in3 = i_inputs[2*DATA_W +: DATA_W];
	assign in4 = i_inputs[3*DATA_W +: DATA_W];
	assign in5 = i_inputs[4*DATA_W +: DATA_W];
	assign go = !i_sm_reset;
	assign big = |{i_inputs[31:25], i_inputs[63:57], i_inputs[95:89],
		i_inputs[127:121], i_inputs[159:153]};
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	a_state_one_hot: assert property ($onehot(o_state))
		else $error("state vector not one-hot");
	a_sm_reset_s1: assert property (i_sm_reset |=> o_state == 5'h01)
		else $error("machine reset did not enter s1");
	a_s1_advance: assert property (o_state[0] && go && in2 == ONE |=> o_state[1])
		else $error("s1 did not advance");
	a_s1_hold: assert property (o_state[0] && go && in2 != ONE |=> $stable(o_state))
		else $error("s1 did not hold");
	a_s2_advance: assert property (o_state[1] && go && in2 == ONE && in3 == ONE
		|=> o_state[2])
		else $error("s2 did not advance");
	a_s3_second_entry: assert property (o_state[2] && go && in4 == ONE && in5 == '0
		|=> o_state[3])
		else $error("s3 second entry ignored");
	a_s4_advance: assert property (o_state[3] && go && in5 == ONE |=> o_state[4])
		else $error("s4 did not advance");
	a_s5_return: assert property (o_state[4] && go |=> o_state[0])
		else $error("s5 did not return to s1");
	a_warn_follows: assert property ($past(i_resetn) |-> o_range_warn == $past(big))
		else $error("range warning wrong");
endmodule

bind ohm_fsm ohm_fsm_properties ohm_fsm_properties_inst (
	.i_clock(i_clock), .i_resetn(i_resetn), .i_sm_reset(i_sm_reset),
	.i_inputs(i_inputs), .o_state(o_state), .o_range_warn(o_range_warn));

`default_nettype wire

/* File: test/test_one_hot_moore_fsm.sv */
/*
 Self-checking bench for ohm_fsm: table walk, random traffic, resets.
 Assumes the default table and the ohm_datapath input model.
*/
`timescale 1ns/10ps
`default_nettype none

module test_one_hot_moore_fsm;
	import ohm_pkg::*;
	logic                         i_clock = 1'b0;
	logic                         i_resetn = 1'b0;
	logic                         i_sm_reset = 1'b0;
	logic [31:0]                  word = 32'h0000_0000;
	logic [NUM_INPUTS*DATA_W-1:0] i_inputs;
	logic [NUM_STATES-1:0]        o_state;
	logic                         o_range_warn;
	logic [31:0]                  walk [8] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0005,
		32'h0000_0000, 32'h0000_0010, 32'h0000_0000, 32'h0000_0040, 32'h0000_0000};
	int                           n_fail = 0;
	int                           samples_checked = 0;
	int                           seed = 10006;
	int                           exp_s = 0;
	logic                         exp_w = 1'b0;

	always #20 i_clock = ~i_clock;

	ohm_datapath ohm_datapath_inst (.i_word(word), .o_inputs(i_inputs));
	ohm_fsm ohm_fsm_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_sm_reset(i_sm_reset),
		.i_inputs(i_inputs), .o_state(o_state), .o_range_warn(o_range_warn));

	function automatic int nxt(int s, logic [31:0] w);
		logic a, b, c;
		a = w[1:0] == 2'h1;
		b = w[3:2] == 2'h1;
		c = w[5:4] == 2'h1;
		case (s)
			0: return a ? 1 : 0;
			1: return (a && b) ? 2 : 1;
			2: return ((a && b && c) || (c && w[7:6] == 2'h0)) ? 3 : 2;
			3: return (w[7:6] == 2'h1) ? 4 : 3;
			default: return 0;
		endcase
	endfunction

	task automatic chk(logic [4:0] got, logic [4:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_warn(logic got, logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic step(logic [31:0] w, logic smr);
		@(negedge i_clock);
		chk(o_state, 5'h01 << exp_s);
		chk_warn(o_range_warn, exp_w);
		word <= w;
		i_sm_reset <= smr;
		exp_s = smr ? 0 : nxt(exp_s, w);
		exp_w = w[31];
	endtask

	task conclude;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (10) @(negedge i_clock);
		chk(o_state, 5'h01);
		i_resetn = 1'b1;
		for (int i = 0; i < 8; i++) step(walk[i], 1'b0);
		$display("walk test done");
		for (int i = 0; i < 400; i++) step($random(seed), ($random(seed) & 15) == 0);
		$display("random test done");
		step(32'h0000_0001, 1'b0);
		@(negedge i_clock);
		chk(o_state, 5'h01 << exp_s);
		i_resetn <= 1'b0;
		word <= 32'h0000_0000;
		#5 chk(o_state, 5'h01);
		@(negedge i_clock);
		i_resetn <= 1'b1;
		exp_s = 0;
		exp_w = 1'b0;
		step(32'h0000_0001, 1'b1);
		step(32'h0000_0000, 1'b0);
		step(32'h0000_0000, 1'b0);
		$display("reset test done");
		conclude;
	end

	initial begin
		#40000;
		n_fail++;
		conclude;
	end
endmodule

`default_nettype wire
